// File: rtl/pmec_regs.v
// Notes on behaviour
// - The received next page word is shown read-only with all fields zero after reset.
// - Function code 00 selects address mode, 01 data mode without post increment, 10 and 11 are reserved, reset 00.
// - The five-bit device select picks the target device (3 is the PCS, 7 auto-negotiation) and resets to zero.
// - In address mode the address/data register holds the device register address to access.
// - In data mode the address/data register reads and writes the device register at the latched address, which stays put.
// - Pulse transmit enable sends link pulses only while sleep is enabled and the port is actually asleep.
// - The transmit interval select gives 1 s, 768 ms, 512 ms or 256 ms, reset 00.
// - Single-pulse wake leaves sleep on one pulse, otherwise two pulses within the receive window are needed.
// - The receive window select gives 64 ms, 256 ms, 512 ms or 1 s between two pulses.
// - Independent mode lets each port transmit pulses alone, otherwise both ports must be asleep.
// - Sleep configuration bits return to defaults on the soft reset issued through the reset control register.
// - Without the energy detect sleep enable no sleep pulse setting has any effect.
`timescale 1ns/1ps
`default_nettype none
`include "pmec_defines.vh"

module pmec_regs #(
  parameter [17:0] CYCLES_PER_MS = `PMEC_CLK_MHZ * `PMEC_US_PER_MS
) (
  input  wire        core_clk,
  input  wire        srst,
  input  wire [4:0]  regAddr,
  input  wire [15:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdData,
  input  wire [15:0] rxNextPage,
  input  wire        rxNextPageValid,
  input  wire        phySoftReset,
  input  wire        energySleepEnable,
  input  wire        sleepSelf,
  input  wire        sleepOther,
  input  wire        linkPulseIn,
  input  wire [15:0] mmdRdData,
  output reg  [4:0]  mmdDevice,
  output wire [15:0] mmdRegAddr,
  output wire [15:0] mmdWrData,
  output wire        mmdWr,
  output wire        mmdRd,
  output reg         txLinkPulse,
  output reg         wakeRequest
);

  // ==========================================================
  // Interval tables in milliseconds
  localparam [9:0] TX_MS0 = `PMEC_TX_INT0_MS;
  localparam [9:0] TX_MS1 = `PMEC_TX_INT1_MS;
  localparam [9:0] TX_MS2 = `PMEC_TX_INT2_MS;
  localparam [9:0] TX_MS3 = `PMEC_TX_INT3_MS;
  localparam [9:0] RX_MS0 = `PMEC_RX_MAX0_MS;
  localparam [9:0] RX_MS1 = `PMEC_RX_MAX1_MS;
  localparam [9:0] RX_MS2 = `PMEC_RX_MAX2_MS;
  localparam [9:0] RX_MS3 = `PMEC_RX_MAX3_MS;

  // ==========================================================
  // Register state
  reg [15:0] nextPageRx;
  reg [1:0]  mmdFunc;
  reg        txEnable;
  reg [1:0]  txIntSel;
  reg        singleWake;
  reg [1:0]  rxMaxSel;
  reg        indepMode;

  wire wrNp   = regWr && (regAddr == `PMEC_IDX_NP_RX);
  wire wrCtrl = regWr && (regAddr == `PMEC_IDX_MMD_CTRL);
  wire wrData = regWr && (regAddr == `PMEC_IDX_MMD_DATA);
  wire wrCfg  = regWr && (regAddr == `PMEC_IDX_PD_CFG);
  wire rdData = regRd && (regAddr == `PMEC_IDX_MMD_DATA);

  wire [15:0] winView;

  // ==========================================================
  // Received next page capture
  always @(posedge core_clk) begin
    if (srst) begin
      nextPageRx <= `PMEC_RST_NP;
    end else if (rxNextPageValid) begin
      nextPageRx <= rxNextPage;
    end
  end

  // ==========================================================
  // Access control register
  always @(posedge core_clk) begin
    if (srst) begin
      mmdFunc   <= `PMEC_RST_FN;
      mmdDevice <= `PMEC_RST_DEV;
    end else if (wrCtrl) begin
      mmdFunc   <= regWrData[`PMEC_FN_HI:`PMEC_FN_LO];
      mmdDevice <= regWrData[`PMEC_DEV_HI:`PMEC_DEV_LO];
    end
  end

  pmec_mmd_access u_mmd (
    .clk        (core_clk),
    .srst       (srst),
    .func       (mmdFunc),
    .winWr      (wrData),
    .winRd      (rdData),
    .winWrData  (regWrData),
    .mmdRdData  (mmdRdData),
    .winView    (winView),
    .mmdRegAddr (mmdRegAddr),
    .mmdWrData  (mmdWrData),
    .mmdWr      (mmdWr),
    .mmdRd      (mmdRd)
  );

  // ==========================================================
  // Sleep pulse configuration, cleared by the soft reset too
  wire cfgReset = srst || phySoftReset;

  always @(posedge core_clk) begin
    if (cfgReset) begin
      txEnable   <= `PMEC_RST_BIT;
      txIntSel   <= `PMEC_RST_SEL;
      singleWake <= `PMEC_RST_BIT;
      rxMaxSel   <= `PMEC_RST_SEL;
      indepMode  <= `PMEC_RST_BIT;
    end else if (wrCfg) begin
      txEnable   <= regWrData[`PMEC_CFG_TXEN];
      txIntSel   <= regWrData[`PMEC_CFG_TXINT_HI:`PMEC_CFG_TXINT_LO];
      singleWake <= regWrData[`PMEC_CFG_SINGLE];
      rxMaxSel   <= regWrData[`PMEC_CFG_RXMAX_HI:`PMEC_CFG_RXMAX_LO];
      indepMode  <= regWrData[`PMEC_CFG_INDEP];
    end
  end

  // ==========================================================
  // Read path
  reg [15:0] nextRdData;

  always @* begin
    nextRdData = `PMEC_RD_ZERO;
    case (regAddr)
      `PMEC_IDX_NP_RX: begin
        nextRdData = nextPageRx;
      end
      `PMEC_IDX_MMD_CTRL: begin
        nextRdData[`PMEC_FN_HI:`PMEC_FN_LO] = mmdFunc;
        nextRdData[`PMEC_DEV_HI:`PMEC_DEV_LO] = mmdDevice;
      end
      `PMEC_IDX_MMD_DATA: begin
        nextRdData = winView;
      end
      `PMEC_IDX_PD_CFG: begin
        nextRdData[`PMEC_CFG_TXEN] = txEnable;
        nextRdData[`PMEC_CFG_TXINT_HI:`PMEC_CFG_TXINT_LO] = txIntSel;
        nextRdData[`PMEC_CFG_SINGLE] = singleWake;
        nextRdData[`PMEC_CFG_RXMAX_HI:`PMEC_CFG_RXMAX_LO] = rxMaxSel;
        nextRdData[`PMEC_CFG_INDEP] = indepMode;
      end
      default: begin
        nextRdData = `PMEC_RD_ZERO;
      end
    endcase
  end

  // Data stand only in the cycle after the strobe
  always @(posedge core_clk) begin
    if (srst) begin
      regRdData <= `PMEC_RD_ZERO;
    end else begin
      regRdData <= regRd ? nextRdData : `PMEC_RD_ZERO;
    end
  end

  // ==========================================================
  // Interval selection
  reg [9:0] txLimit;
  reg [9:0] rxLimit;

  always @* begin
    case (txIntSel)
      `PMEC_SEL_0: txLimit = TX_MS0;
      `PMEC_SEL_1: txLimit = TX_MS1;
      `PMEC_SEL_2: txLimit = TX_MS2;
      default:     txLimit = TX_MS3;
    endcase
  end

  always @* begin
    case (rxMaxSel)
      `PMEC_SEL_0: rxLimit = RX_MS0;
      `PMEC_SEL_1: rxLimit = RX_MS1;
      `PMEC_SEL_2: rxLimit = RX_MS2;
      default:     rxLimit = RX_MS3;
    endcase
  end

  // ==========================================================
  // Transmit link pulses during sleep
  wire asleep   = energySleepEnable && sleepSelf;
  wire txActive = txEnable && asleep &&
                  (indepMode || sleepOther);
  wire txMsTick;
  wire txHit;

  pmec_tick_counter #(.W(`PMEC_PRE_W)) u_txPre (
    .clk   (core_clk),
    .srst  (srst),
    .clr   (!txActive),
    .en    (txActive),
    .limit (CYCLES_PER_MS),
    .hit   (txMsTick)
  );

  pmec_tick_counter #(.W(`PMEC_MS_W)) u_txMs (
    .clk   (core_clk),
    .srst  (srst),
    .clr   (!txActive),
    .en    (txMsTick),
    .limit (txLimit),
    .hit   (txHit)
  );

  always @(posedge core_clk) begin
    if (srst) begin
      txLinkPulse <= 1'b0;
    end else begin
      txLinkPulse <= txHit;
    end
  end

  // ==========================================================
  // Wake detection; the pulse input is asynchronous
  reg pulseMeta;
  reg pulseSync;
  reg pulseLast;
  reg armed;

  wire pulseEdge = pulseSync && !pulseLast;
  wire rxRun     = armed && !pulseEdge;
  wire rxMsTick;
  wire gapHit;

  always @(posedge core_clk) begin
    if (srst) begin
      pulseMeta <= 1'b0;
      pulseSync <= 1'b0;
      pulseLast <= 1'b0;
    end else begin
      pulseMeta <= linkPulseIn;
      pulseSync <= pulseMeta;
      pulseLast <= pulseSync;
    end
  end

  // Window restarts at every pulse so the gap is measured pulse to pulse
  pmec_tick_counter #(.W(`PMEC_PRE_W)) u_rxPre (
    .clk   (core_clk),
    .srst  (srst),
    .clr   (!rxRun),
    .en    (rxRun),
    .limit (CYCLES_PER_MS),
    .hit   (rxMsTick)
  );

  pmec_tick_counter #(.W(`PMEC_MS_W)) u_rxMs (
    .clk   (core_clk),
    .srst  (srst),
    .clr   (!rxRun),
    .en    (rxMsTick),
    .limit (rxLimit),
    .hit   (gapHit)
  );

  always @(posedge core_clk) begin
    if (srst) begin
      armed       <= 1'b0;
      wakeRequest <= 1'b0;
    end else begin
      wakeRequest <= 1'b0;
      if (!asleep) begin
        armed <= 1'b0;
      end else if (pulseEdge) begin
        if (singleWake || armed) begin
          wakeRequest <= 1'b1;
          armed       <= 1'b0;
        end else begin
          armed <= 1'b1;
        end
      end else if (gapHit) begin
        armed <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/pmec_defines.vh
`ifndef PMEC_DEFINES_VH
`define PMEC_DEFINES_VH

// ==========================================================
// Register indices
`define PMEC_ADDR_W          5
`define PMEC_DATA_W          16
`define PMEC_IDX_NP_RX       5'h08
`define PMEC_IDX_MMD_CTRL    5'h0d
`define PMEC_IDX_MMD_DATA    5'h0e
`define PMEC_IDX_PD_CFG      5'h10

// ==========================================================
// Field positions
`define PMEC_FN_HI           15
`define PMEC_FN_LO           14
`define PMEC_DEV_HI          4
`define PMEC_DEV_LO          0
`define PMEC_CFG_TXEN        15
`define PMEC_CFG_TXINT_HI    14
`define PMEC_CFG_TXINT_LO    13
`define PMEC_CFG_SINGLE      12
`define PMEC_CFG_RXMAX_HI    11
`define PMEC_CFG_RXMAX_LO    10
`define PMEC_CFG_INDEP       3

// ==========================================================
// Encodings
`define PMEC_FN_ADDR         2'h0
`define PMEC_FN_DATA         2'h1
`define PMEC_DEV_PCS         5'h03
`define PMEC_DEV_AN          5'h07
`define PMEC_SEL_0           2'h0
`define PMEC_SEL_1           2'h1
`define PMEC_SEL_2           2'h2

// ==========================================================
// Reset values
`define PMEC_RST_NP          16'h0000
`define PMEC_RST_FN          2'h0
`define PMEC_RST_DEV         5'h00
`define PMEC_RST_ADDR        16'h0000
`define PMEC_RST_BIT         1'h0
`define PMEC_RST_SEL         2'h0
`define PMEC_RD_ZERO         16'h0000

// ==========================================================
// Timing, in milliseconds and clock rate
`define PMEC_TX_INT0_MS      1000
`define PMEC_TX_INT1_MS      768
`define PMEC_TX_INT2_MS      512
`define PMEC_TX_INT3_MS      256
`define PMEC_RX_MAX0_MS      64
`define PMEC_RX_MAX1_MS      256
`define PMEC_RX_MAX2_MS      512
`define PMEC_RX_MAX3_MS      1000
`define PMEC_CLK_MHZ         250
`define PMEC_US_PER_MS       1000
`define PMEC_MS_W            10
`define PMEC_PRE_W           18

`endif

// File: rtl/pmec_tick_counter.v
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Wrapping counter; hit marks the last count of each period
module pmec_tick_counter #(
  parameter W = 10
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         clr,
  input  wire         en,
  input  wire [W-1:0] limit,
  output wire         hit
);

  reg [W-1:0] count;

  assign hit = en && (count == limit - 1'b1);

  always @(posedge clk) begin
    if (srst || clr) begin
      count <= {W{1'b0}};
    end else if (en) begin
      count <= hit ? {W{1'b0}} : count + 1'b1;
    end
  end

endmodule

`default_nettype wire

// File: rtl/pmec_mmd_access.v
`timescale 1ns/1ps
`default_nettype none
`include "pmec_defines.vh"

// ==========================================================
// Indirect window into the manageable device space
module pmec_mmd_access (
  input  wire        clk,
  input  wire        srst,
  input  wire [1:0]  func,
  input  wire        winWr,
  input  wire        winRd,
  input  wire [15:0] winWrData,
  input  wire [15:0] mmdRdData,
  output wire [15:0] winView,
  output reg  [15:0] mmdRegAddr,
  output reg  [15:0] mmdWrData,
  output reg         mmdWr,
  output reg         mmdRd
);

  wire isAddr = (func == `PMEC_FN_ADDR);
  wire isData = (func == `PMEC_FN_DATA);

  // Reserved function codes open no access and read zero
  assign winView = isAddr ? mmdRegAddr :
                   isData ? mmdRdData : `PMEC_RD_ZERO;

  always @(posedge clk) begin
    if (srst) begin
      mmdRegAddr <= `PMEC_RST_ADDR;
      mmdWrData  <= `PMEC_RST_ADDR;
      mmdWr      <= 1'b0;
      mmdRd      <= 1'b0;
    end else begin
      mmdWr <= winWr && isData;
      mmdRd <= winRd && isData;
      if (winWr && isAddr) begin
        mmdRegAddr <= winWrData;
      end
      if (winWr && isData) begin
        mmdWrData <= winWrData;
      end
    end
  end

endmodule

`default_nettype wire

// File: tb/pmec_regs_props.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port-level properties of the register block
module pmec_regs_props #(
  parameter [17:0] CYCLES_PER_MS = 18'd4
) (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic [4:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  input wire logic        energySleepEnable,
  input wire logic        sleepSelf,
  input wire logic [4:0]  mmdDevice,
  input wire logic [15:0] mmdRegAddr,
  input wire logic [15:0] mmdWrData,
  input wire logic        mmdWr,
  input wire logic        mmdRd,
  input wire logic        txLinkPulse,
  input wire logic        wakeRequest
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  unmapped_zero_a:
    assert property (regRd && !(regAddr inside {5'h08, 5'h0d, 5'h0e, 5'h10})
      |=> regRdData == 16'h0000) else $error("unmapped read not zero");
  ctrl_reserved_a:
    assert property (regRd && regAddr == 5'h0d |=> regRdData[13:5] == 9'h0)
      else $error("control reserved bits set");
  cfg_reserved_a:
    assert property (regRd && regAddr == 5'h10 |=> regRdData[9:4] == 6'h0
      && regRdData[2:0] == 3'h0) else $error("config reserved bits set");
  dev_select_a:
    assert property ($changed(mmdDevice) |-> $past(regWr) && $past(regAddr)
      == 5'h0d && mmdDevice == $past(regWrData[4:0]))
      else $error("device select moved without write");
  addr_latch_a:
    assert property ($changed(mmdRegAddr) |-> $past(regWr) && $past(regAddr)
      == 5'h0e && mmdRegAddr == $past(regWrData))
      else $error("device address moved without write");
  window_write_a:
    assert property (mmdWr |-> $past(regWr) && $past(regAddr) == 5'h0e
      && mmdWrData == $past(regWrData)) else $error("stray device write");
  window_read_a:
    assert property (mmdRd |-> $past(regRd) && $past(regAddr) == 5'h0e)
      else $error("stray device read");
  tx_gate_a:
    assert property (txLinkPulse |-> $past(energySleepEnable)
      && $past(sleepSelf)) else $error("link pulse while awake");
  tx_space_a:
    assert property (txLinkPulse |=> !txLinkPulse [*8])
      else $error("link pulses too close");
  wake_gate_a:
    assert property (wakeRequest |-> $past(energySleepEnable)
      && $past(sleepSelf)) else $error("wake while not asleep");
endmodule

bind pmec_regs pmec_regs_props #(.CYCLES_PER_MS(CYCLES_PER_MS))
  pmec_regs_props_i (.core_clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
  .regRdData, .energySleepEnable, .sleepSelf, .mmdDevice, .mmdRegAddr,
  .mmdWrData, .mmdWr, .mmdRd, .txLinkPulse, .wakeRequest);

`default_nettype wire

// File: tb/tb_pmec_regs.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pmec_regs;
  // ==========================================================
  // Signals; short millisecond keeps the interval tests brief
  localparam int CPM = 4;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic [4:0]  regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [15:0] rxNextPage = 16'h0000;
  logic        rxNextPageValid = 1'b0;
  logic        phySoftReset = 1'b0;
  logic        energySleepEnable = 1'b0;
  logic        sleepSelf = 1'b0;
  logic        sleepOther = 1'b0;
  logic        linkPulseIn = 1'b0;
  logic [15:0] mmdRdData = 16'h0000;
  logic [15:0] regRdData;
  logic [4:0]  mmdDevice;
  logic [15:0] mmdRegAddr;
  logic [15:0] mmdWrData;
  logic        mmdWr;
  logic        mmdRd;
  logic        txLinkPulse;
  logic        wakeRequest;
  int          nErrors = 0;
  int          checksDone = 0;
  int          wakes = 0;
  int          cycles = 0;

  pmec_regs #(.CYCLES_PER_MS(18'(CPM))) pmec_regs_i (.core_clk, .srst,
    .regAddr, .regWrData, .regWr, .regRd, .regRdData, .rxNextPage,
    .rxNextPageValid, .phySoftReset, .energySleepEnable, .sleepSelf,
    .sleepOther, .linkPulseIn, .mmdRdData, .mmdDevice, .mmdRegAddr,
    .mmdWrData, .mmdWr, .mmdRd, .txLinkPulse, .wakeRequest);

  initial forever #2 core_clk = ~core_clk;

  // ==========================================================
  // Shared tasks
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checksDone++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  task rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1 chk(regRdData, e);
  endtask

  task nlp;
    @(posedge core_clk);
    linkPulseIn <= 1'b1;
    repeat (3) @(posedge core_clk);
    linkPulseIn <= 1'b0;
  endtask

  // Cycles to the next link pulse, capped so a silent port cannot hang
  task txGap(output int n);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (txLinkPulse !== 1'b1 && n < 5000);
  endtask

  task results;
    $display("checks %0d errors %0d", checksDone, nErrors);
    if (nErrors == 0 && checksDone > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (wakeRequest === 1'b1)
      wakes <= wakes + 1;
    if (cycles == 60000) begin
      nErrors++;
      results();
    end
  end

  // ==========================================================
  // Scenarios
  task tRegs;
    rd(5'h08, 16'h0000);
    rd(5'h0d, 16'h0000);
    rd(5'h0e, 16'h0000);
    rd(5'h10, 16'h0000);
    rd(5'h05, 16'h0000);
    @(posedge core_clk);
    rxNextPage <= 16'ha5c3;
    rxNextPageValid <= 1'b1;
    @(posedge core_clk);
    rxNextPageValid <= 1'b0;
    wr(5'h08, 16'h1111);
    rd(5'h08, 16'ha5c3);
    wr(5'h10, 16'hffff);
    rd(5'h10, 16'hfc08);
    @(posedge core_clk);
    phySoftReset <= 1'b1;
    @(posedge core_clk);
    phySoftReset <= 1'b0;
    rd(5'h10, 16'h0000);
    $display("test registers done");
  endtask

  task tMmd;
    @(posedge core_clk);
    mmdRdData <= 16'h5a5a;
    wr(5'h0d, 16'hffff);
    rd(5'h0d, 16'hc01f);
    wr(5'h0d, 16'h0003);
    wr(5'h0e, 16'h1234);
    #1 chk(mmdRegAddr, 16'h1234);
    chk({11'h0, mmdDevice}, 16'h0003);
    rd(5'h0e, 16'h1234);
    wr(5'h0d, 16'h4007);
    wr(5'h0e, 16'hbeef);
    #1 chk({15'h0, mmdWr}, 16'h0001);
    chk(mmdWrData, 16'hbeef);
    chk(mmdRegAddr, 16'h1234);
    rd(5'h0e, 16'h5a5a);
    chk({15'h0, mmdRd}, 16'h0001);
    wr(5'h0d, 16'h8007);
    wr(5'h0e, 16'h1111);
    #1 chk({15'h0, mmdWr}, 16'h0000);
    rd(5'h0e, 16'h0000);
    wr(5'h0d, 16'h0007);
    rd(5'h0e, 16'h1234);
    $display("test window done");
  endtask

  task tTx;
    int n;
    int ms [4] = '{1000, 768, 512, 256};
    energySleepEnable <= 1'b1;
    sleepSelf <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(5'h10, 16'h0000);
      wr(5'h10, {1'b1, 2'(i), 9'h0, 1'b1, 3'h0});
      txGap(n);
      txGap(n);
      chk(16'(n), 16'(ms[i] * CPM));
    end
    wr(5'h10, 16'he000);
    txGap(n);
    chk(16'(n), 16'd5000);
    sleepOther <= 1'b1;
    txGap(n);
    txGap(n);
    chk(16'(n), 16'(256 * CPM));
    energySleepEnable <= 1'b0;
    txGap(n);
    chk(16'(n), 16'd5000);
    $display("test pulses done");
  endtask

  task tWake;
    int w;
    energySleepEnable <= 1'b1;
    wr(5'h10, 16'h1000);
    w = wakes;
    nlp();
    repeat (8) @(posedge core_clk);
    chk(16'(wakes - w), 16'd1);
    wr(5'h10, 16'h0000);
    w = wakes;
    nlp();
    repeat (300) @(posedge core_clk);
    chk(16'(wakes - w), 16'd0);
    // A pulse after the window has closed must only re-arm
    nlp();
    repeat (8) @(posedge core_clk);
    chk(16'(wakes - w), 16'd0);
    repeat (192) @(posedge core_clk);
    nlp();
    repeat (8) @(posedge core_clk);
    chk(16'(wakes - w), 16'd1);
    wr(5'h10, 16'h0400);
    nlp();
    repeat (800) @(posedge core_clk);
    nlp();
    repeat (8) @(posedge core_clk);
    chk(16'(wakes - w), 16'd2);
    $display("test wake done");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    tRegs();
    tMmd();
    tTx();
    tWake();
    results();
  end
endmodule

`default_nettype wire
